/* File: verilog/dcf_pkg.sv */
// dcf_pkg: constants and the pin carrier type of the dual-clock fifo with mailboxes.
// assumes one system clock samples both port clocks as plain inputs.
package dcf_pkg;
   localparam int DATA_W = 36;
   localparam int ADDR_W = 6;
   localparam int PTR_W = 7;
   localparam logic [6:0] DEPTH_CNT = 7'h40;
   localparam logic [6:0] OFS_HH = 7'h10;
   localparam logic [6:0] OFS_HL = 7'h0C;
   localparam logic [6:0] OFS_LH = 7'h08;
   localparam logic [6:0] OFS_LL = 7'h04;
   localparam logic [1:0] WAKE_EDGES = 2'h2;
   localparam logic FULL_N_RST = 1'b0;
   localparam logic EMPTY_N_RST = 1'b0;
   localparam logic AE_N_RST = 1'b0;
   localparam logic AF_N_RST = 1'b1;
   localparam logic MAIL_N_RST = 1'b1;
   localparam logic OE_N_RST = 1'b1;

   typedef struct packed {
      logic clk;
      logic sel_n;
      logic wnr;
      logic en;
      logic mb;
      logic [DATA_W-1:0] data;
   } dcf_pin_t;
endpackage : dcf_pkg

/* File: verilog/dcf_fifo_top.sv */
// dcf_fifo_top: 64 x 36 fifo from port A to port B, two mailboxes,
// offset-programmed almost flags and bus enables for both ports.
// assumes CLK runs at least four times faster than either port clock;
// all pins, port clocks included, are sampled on CLK.
`timescale 1ns/1ns

// Summary of operation
// - device reset may change at any time; it is synchronised first.
// - reset clears pointers; full, empty, almost-empty low; almost-full, mail high.
// - full flag rises on second write-port clock edge after reset release.
// - reset release loads offset 16, 12, 8 or 4 from select pins.
// - bus drives only while select and write-not-read are both low.
// - port A edge with write, enable, no mailbox, not full stores a word.
// - port B edge with read, enable, no mailbox, not empty fetches a word.
// - port A mailbox write loads A-to-B; read sets B-to-A flag high.
// - port B mailbox write loads B-to-A; read sets A-to-B flag high.
// - each fifo flag's far pointer passes two stages on the flag's own port clock.
// - empty flag low means fifo reads are ignored.
// - read pointer steps by one per word fetched.
// - new word readable no sooner than three read-clock cycles after write.
// - empty flag rises on second read-clock edge after the write.
// - a read-clock edge too close to the write is not counted.
// - full flag low means fifo writes are ignored.
// - write pointer steps by one per word written.
// - freed location writable no sooner than three write-clock cycles later.
// - full flag rises on second write-clock edge after such a read.
// - almost-empty low at offset words or fewer, high above.
// - almost-full low at sixty-four minus offset words or more.
// - mailbox write drops its flag; further writes ignored while flag low.
module dcf_fifo_top (
   input wire logic CLK, // system clock, 20 MHz
   input wire logic RESET, // synchronous reset, active high
   input wire logic DEVICE_RESET_N, // device reset pin, active low
   input wire logic OFFSET_SELECT_LO, // offset select, low bit
   input wire logic OFFSET_SELECT_HI, // offset select, high bit
   input wire logic WRITE_PORT_CLOCK, // port A clock pin
   input wire logic PORT_A_SELECT_N, // port A chip select
   input wire logic PORT_A_WRITE_NOT_READ, // port A direction
   input wire logic PORT_A_ENABLE, // port A transfer enable
   input wire logic PORT_A_MAILBOX_SELECT, // port A mailbox select
   input wire logic [35:0] PORT_A_BUS_IN, // port A bus level
   output logic [35:0] PORT_A_BUS_OUT, // port A bus drive value
   output logic PORT_A_BUS_OE_N, // port A drive, low drives
   input wire logic READ_PORT_CLOCK, // port B clock pin
   input wire logic PORT_B_SELECT_N, // port B chip select
   input wire logic PORT_B_WRITE_NOT_READ, // port B direction
   input wire logic PORT_B_ENABLE, // port B transfer enable
   input wire logic PORT_B_MAILBOX_SELECT, // port B mailbox select
   input wire logic [35:0] PORT_B_BUS_IN, // port B bus level
   output logic [35:0] PORT_B_BUS_OUT, // port B bus drive value
   output logic PORT_B_BUS_OE_N, // port B drive, low drives
   output logic FULL_FLAG_N, // low when full
   output logic ALMOST_FULL_N, // low when almost full
   output logic EMPTY_FLAG_N, // low when empty
   output logic ALMOST_EMPTY_N, // low when almost empty
   output logic A_TO_B_MAIL_FLAG_N, // low when A-to-B mail waits
   output logic B_TO_A_MAIL_FLAG_N // low when B-to-A mail waits
);
   dcf_pkg::dcf_pin_t pin_in [2];
   dcf_pkg::dcf_pin_t s1_ff [2];
   dcf_pkg::dcf_pin_t s2_ff [2];
   dcf_pkg::dcf_pin_t s3_ff [2];
   logic [2:0] m_s1_ff, m_s2_ff;
   logic rstn_prev_ff;
   logic dev_rst, rst_rise;
   logic a_edge, b_edge, a_go, b_go;
   logic fifo_wr, fifo_rd, mail_a_wr, mail_a_rd, mail_b_wr, mail_b_rd;
   logic [35:0] mem [64];
   logic [6:0] wr_ptr_ff, wr_gray_ff, rd_ptr_ff, rd_gray_ff;
   logic [6:0] rg_a1_ff, rg_a2_ff, wg_b1_ff, wg_b2_ff;
   logic [6:0] a_count, b_count, offset_ff;
   logic [1:0] wake_ff;
   logic [35:0] out_reg_ff, a2b_mail_ff, b2a_mail_ff;
   logic [35:0] a_out_ff, b_out_ff;
   logic a_oe_n_ff, b_oe_n_ff;
   logic full_n_ff, af_n_ff, empty_n_ff, ae_n_ff, a2b_n_ff, b2a_n_ff;

   function automatic logic [6:0] to_gray(input logic [6:0] b);
      return b ^ (b >> 1);
   endfunction : to_gray

   function automatic logic [6:0] from_gray(input logic [6:0] g);
      logic [6:0] b;
      b[6] = g[6];
      for (int i = 5; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : from_gray

   assign pin_in[0] = '{WRITE_PORT_CLOCK, PORT_A_SELECT_N,
      PORT_A_WRITE_NOT_READ, PORT_A_ENABLE, PORT_A_MAILBOX_SELECT,
      PORT_A_BUS_IN};
   assign pin_in[1] = '{READ_PORT_CLOCK, PORT_B_SELECT_N,
      PORT_B_WRITE_NOT_READ, PORT_B_ENABLE, PORT_B_MAILBOX_SELECT,
      PORT_B_BUS_IN};

   // two stages, then a third so the clock edge finds pre-edge controls
   for (genvar gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
         if (RESET) begin
            s1_ff[gi] <= '0;
            s2_ff[gi] <= '0;
            s3_ff[gi] <= '0;
         end else begin
            s1_ff[gi] <= pin_in[gi];
            s2_ff[gi] <= s1_ff[gi];
            s3_ff[gi] <= s2_ff[gi];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         m_s1_ff <= 3'h0;
         m_s2_ff <= 3'h0;
         rstn_prev_ff <= 1'b0;
      end else begin
         m_s1_ff <= {DEVICE_RESET_N, OFFSET_SELECT_HI, OFFSET_SELECT_LO};
         m_s2_ff <= m_s1_ff;
         rstn_prev_ff <= m_s2_ff[2];
      end
   end

   assign dev_rst = RESET | ~m_s2_ff[2];
   assign rst_rise = m_s2_ff[2] & ~rstn_prev_ff;
   assign a_edge = s2_ff[0].clk & ~s3_ff[0].clk;
   assign b_edge = s2_ff[1].clk & ~s3_ff[1].clk;
   assign a_go = a_edge & ~s3_ff[0].sel_n & s3_ff[0].en & ~dev_rst;
   assign b_go = b_edge & ~s3_ff[1].sel_n & s3_ff[1].en & ~dev_rst;
   assign fifo_wr = a_go & s3_ff[0].wnr & ~s3_ff[0].mb & full_n_ff;
   assign fifo_rd = b_go & ~s3_ff[1].wnr & ~s3_ff[1].mb & empty_n_ff;
   assign mail_a_wr = a_go & s3_ff[0].wnr & s3_ff[0].mb;
   assign mail_a_rd = a_go & ~s3_ff[0].wnr & s3_ff[0].mb;
   assign mail_b_wr = b_go & s3_ff[1].wnr & s3_ff[1].mb;
   assign mail_b_rd = b_go & ~s3_ff[1].wnr & s3_ff[1].mb;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         offset_ff <= dcf_pkg::OFS_LL;
      end else if (rst_rise) begin
         unique case (m_s2_ff[1:0])
            2'h3: offset_ff <= dcf_pkg::OFS_HH;
            2'h2: offset_ff <= dcf_pkg::OFS_HL;
            2'h1: offset_ff <= dcf_pkg::OFS_LH;
            2'h0: offset_ff <= dcf_pkg::OFS_LL;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (fifo_wr) begin
         mem[wr_ptr_ff[5:0]] <= s3_ff[0].data;
      end
   end

   always_ff @(posedge CLK) begin
      if (dev_rst) begin
         wr_ptr_ff <= 7'h00;
         wr_gray_ff <= 7'h00;
      end else if (fifo_wr) begin
         wr_ptr_ff <= wr_ptr_ff + 7'h01;
         wr_gray_ff <= to_gray(wr_ptr_ff + 7'h01);
      end
   end

   always_ff @(posedge CLK) begin
      if (dev_rst) begin
         rd_ptr_ff <= 7'h00;
         rd_gray_ff <= 7'h00;
         out_reg_ff <= 36'h000000000;
      end else if (fifo_rd) begin
         out_reg_ff <= mem[rd_ptr_ff[5:0]];
         rd_ptr_ff <= rd_ptr_ff + 7'h01;
         rd_gray_ff <= to_gray(rd_ptr_ff + 7'h01);
      end
   end

   // pointer crossings step only on the far port's clock edges, so a
   // change just before an edge waits one more port cycle
   always_ff @(posedge CLK) begin
      if (dev_rst) begin
         rg_a1_ff <= 7'h00;
         rg_a2_ff <= 7'h00;
      end else if (a_edge) begin
         rg_a1_ff <= rd_gray_ff;
         rg_a2_ff <= rg_a1_ff;
      end
   end

   always_ff @(posedge CLK) begin
      if (dev_rst) begin
         wg_b1_ff <= 7'h00;
         wg_b2_ff <= 7'h00;
      end else if (b_edge) begin
         wg_b1_ff <= wr_gray_ff;
         wg_b2_ff <= wg_b1_ff;
      end
   end

   assign a_count = wr_ptr_ff - from_gray(rg_a2_ff);
   assign b_count = from_gray(wg_b2_ff) - rd_ptr_ff;

   always_ff @(posedge CLK) begin
      if (dev_rst) begin
         wake_ff <= 2'h0;
         full_n_ff <= dcf_pkg::FULL_N_RST;
         af_n_ff <= dcf_pkg::AF_N_RST;
      end else begin
         // an edge sampled together with the release belongs to reset
         if (a_edge && rstn_prev_ff && wake_ff != dcf_pkg::WAKE_EDGES) begin
            wake_ff <= wake_ff + 2'h1;
         end
         full_n_ff <= (wake_ff == dcf_pkg::WAKE_EDGES) &&
            (a_count != dcf_pkg::DEPTH_CNT);
         af_n_ff <= a_count < (dcf_pkg::DEPTH_CNT - offset_ff);
      end
   end

   always_ff @(posedge CLK) begin
      if (dev_rst) begin
         empty_n_ff <= dcf_pkg::EMPTY_N_RST;
         ae_n_ff <= dcf_pkg::AE_N_RST;
      end else begin
         empty_n_ff <= b_count != 7'h00;
         ae_n_ff <= b_count > offset_ff;
      end
   end

   // a write in the same cycle as the far read wins while the box is free; with mail waiting the read wins and the write is dropped
   always_ff @(posedge CLK) begin
      if (dev_rst) begin
         a2b_n_ff <= dcf_pkg::MAIL_N_RST;
         b2a_n_ff <= dcf_pkg::MAIL_N_RST;
      end else begin
         if (mail_a_wr && a2b_n_ff) begin
            a2b_n_ff <= 1'b0;
         end else if (mail_b_rd) begin
            a2b_n_ff <= 1'b1;
         end
         if (mail_b_wr && b2a_n_ff) begin
            b2a_n_ff <= 1'b0;
         end else if (mail_a_rd) begin
            b2a_n_ff <= 1'b1;
         end
      end
   end

   // mail data survives device reset; only the system reset clears it
   always_ff @(posedge CLK) begin
      if (RESET) begin
         a2b_mail_ff <= 36'h000000000;
         b2a_mail_ff <= 36'h000000000;
      end else begin
         if (mail_a_wr && a2b_n_ff) begin
            a2b_mail_ff <= s3_ff[0].data;
         end
         if (mail_b_wr && b2a_n_ff) begin
            b2a_mail_ff <= s3_ff[1].data;
         end
      end
   end

   // enables follow the pins with no clock edge needed, only sampling
   always_ff @(posedge CLK) begin
      if (dev_rst) begin
         a_oe_n_ff <= dcf_pkg::OE_N_RST;
         b_oe_n_ff <= dcf_pkg::OE_N_RST;
         a_out_ff <= 36'h000000000;
         b_out_ff <= 36'h000000000;
      end else begin
         a_oe_n_ff <= s2_ff[0].sel_n | s2_ff[0].wnr;
         b_oe_n_ff <= s2_ff[1].sel_n | s2_ff[1].wnr;
         a_out_ff <= b2a_mail_ff;
         b_out_ff <= s2_ff[1].mb ? a2b_mail_ff : out_reg_ff;
      end
   end

   assign PORT_A_BUS_OUT = a_out_ff;
   assign PORT_A_BUS_OE_N = a_oe_n_ff;
   assign PORT_B_BUS_OUT = b_out_ff;
   assign PORT_B_BUS_OE_N = b_oe_n_ff;
   assign FULL_FLAG_N = full_n_ff;
   assign ALMOST_FULL_N = af_n_ff;
   assign EMPTY_FLAG_N = empty_n_ff;
   assign ALMOST_EMPTY_N = ae_n_ff;
   assign A_TO_B_MAIL_FLAG_N = a2b_n_ff;
   assign B_TO_A_MAIL_FLAG_N = b2a_n_ff;

   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);

   a_reset_flags: assert property (dev_rst |=> !FULL_FLAG_N &&
      !EMPTY_FLAG_N && !ALMOST_EMPTY_N && ALMOST_FULL_N &&
      A_TO_B_MAIL_FLAG_N && B_TO_A_MAIL_FLAG_N)
      else $error("device reset flag values wrong");
   a_full_wake: assert property ((wake_ff != 2'h2) |=>
      !FULL_FLAG_N) else $error("full flag high too early");
   a_offset_load: assert property (rst_rise |=> offset_ff ==
      7'(({5'h00, $past(m_s2_ff[1:0])} + 7'h01) << 2))
      else $error("offset not loaded from select pins");
   a_bus_decode: assert property (!dev_rst |=> PORT_B_BUS_OE_N ==
      ($past(s2_ff[1].sel_n) | $past(s2_ff[1].wnr)))
      else $error("port B drive enable wrong");
   a_full_ignore: assert property ((a_edge && !full_n_ff) |=>
      $stable(wr_ptr_ff)) else $error("write taken while full");
   a_write_step: assert property (fifo_wr |=> wr_ptr_ff ==
      $past(wr_ptr_ff) + 7'h01) else $error("write pointer step");
   a_empty_ignore: assert property ((b_edge && !empty_n_ff) |=>
      $stable(rd_ptr_ff)) else $error("read taken while empty");
   a_read_step: assert property (fifo_rd |=> rd_gray_ff ==
      to_gray($past(rd_ptr_ff) + 7'h01)) else $error("read pointer step");
   a_mail_lock: assert property ((mail_a_wr && !a2b_n_ff) |=>
      $stable(a2b_mail_ff)) else $error("locked mailbox overwritten");
   a_mail_read: assert property ((mail_a_rd && !mail_b_wr) |=>
      B_TO_A_MAIL_FLAG_N) else $error("mail read left flag low");
   a_mail_b_read: assert property ((mail_b_rd && !mail_a_wr) |=>
      A_TO_B_MAIL_FLAG_N) else $error("mail read left flag low");
endmodule : dcf_fifo_top

/* File: test/dcf_port_master.sv */
// dcf_port_master: bus master model for one port; makes the port clock.
// assumes the system clock drives it; controls change on its falling edge.
`timescale 1ns/1ns
module dcf_port_master #(
   parameter int HALF = 4
) (
   input wire logic clk, // system clock
   input wire logic [35:0] dev_bus, // device drive value
   input wire logic dev_oe_n, // low while the device drives
   output dcf_pkg::dcf_pin_t pins // pins as the device sees them
);
   logic pclk = 1'h0;
   logic sel_n = 1'h1;
   logic wnr = 1'h1;
   logic en = 1'h0;
   logic mb = 1'h0;
   logic [35:0] drv = 36'h0;
   logic [35:0] last = 36'h0;
   logic [35:0] lvl;
   int cnt = 0;
   // a released bus toggles so a stale word can never pass for data
   assign lvl = !dev_oe_n ? dev_bus : (wnr ? drv : ~last);
   assign pins = {pclk, sel_n, wnr, en, mb, lvl};
   always @(negedge clk) begin
      last <= lvl;
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
         pclk <= ~pclk;
      end
   end
   // controls move early in the low phase, well clear of the rise
   task automatic xfer(input logic s, input logic w, input logic e,
         input logic m, input logic [35:0] d);
      @(negedge pclk);
      @(negedge clk);
      sel_n = s;
      wnr = w;
      en = e;
      mb = m;
      drv = d;
      @(posedge pclk);
   endtask : xfer
   task automatic idle();
      @(negedge pclk);
      @(negedge clk);
      en = 1'h0;
   endtask : idle
endmodule : dcf_port_master

/* File: test/dcf_fifo_tb.sv */
// dual_clock_fifo_mailbox_ports_tb_top: self-checking bench of dcf_fifo_top.
// assumes two dcf_port_master models drive ports A and B.
`timescale 1ns/1ns
module dual_clock_fifo_mailbox_ports_tb_top;
   logic clk, reset, dev_rst_n, fs_lo, fs_hi;
   logic [35:0] a_out, b_out, w, m1, m2;
   logic a_oe_n, b_oe_n, full_n, af_n, empty_n, ae_n, mab_n, mba_n;
   dcf_pkg::dcf_pin_t pa, pb;
   logic [35:0] q[$];
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   int x;
   dcf_port_master #(.HALF(4)) dcf_port_master_inst_a (.clk(clk),
      .dev_bus(a_out), .dev_oe_n(a_oe_n), .pins(pa));
   dcf_port_master #(.HALF(5)) dcf_port_master_inst_b (.clk(clk),
      .dev_bus(b_out), .dev_oe_n(b_oe_n), .pins(pb));
   dcf_fifo_top dcf_fifo_top_inst (.CLK(clk), .RESET(reset),
      .DEVICE_RESET_N(dev_rst_n), .OFFSET_SELECT_LO(fs_lo),
      .OFFSET_SELECT_HI(fs_hi), .WRITE_PORT_CLOCK(pa.clk),
      .PORT_A_SELECT_N(pa.sel_n), .PORT_A_WRITE_NOT_READ(pa.wnr),
      .PORT_A_ENABLE(pa.en), .PORT_A_MAILBOX_SELECT(pa.mb),
      .PORT_A_BUS_IN(pa.data), .PORT_A_BUS_OUT(a_out),
      .PORT_A_BUS_OE_N(a_oe_n), .READ_PORT_CLOCK(pb.clk),
      .PORT_B_SELECT_N(pb.sel_n), .PORT_B_WRITE_NOT_READ(pb.wnr),
      .PORT_B_ENABLE(pb.en), .PORT_B_MAILBOX_SELECT(pb.mb),
      .PORT_B_BUS_IN(pb.data), .PORT_B_BUS_OUT(b_out),
      .PORT_B_BUS_OE_N(b_oe_n), .FULL_FLAG_N(full_n),
      .ALMOST_FULL_N(af_n), .EMPTY_FLAG_N(empty_n),
      .ALMOST_EMPTY_N(ae_n), .A_TO_B_MAIL_FLAG_N(mab_n),
      .B_TO_A_MAIL_FLAG_N(mba_n));
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [35:0] rnd36();
      logic [63:0] r;
      r = {$urandom(), $urandom()};
      return r[35:0];
   endfunction : rnd36
   function automatic int ofs(input logic [1:0] fs);
      case (fs)
         2'h3: return int'(dcf_pkg::OFS_HH);
         2'h2: return int'(dcf_pkg::OFS_HL);
         2'h1: return int'(dcf_pkg::OFS_LH);
         default: return int'(dcf_pkg::OFS_LL);
      endcase
   endfunction : ofs
   // both ports drop enable together so neither repeats its last transfer
   task automatic settle();
      fork
         dcf_port_master_inst_a.idle();
         dcf_port_master_inst_b.idle();
      join
      repeat (4) @(posedge pb.clk);
      repeat (5) @(negedge clk);
   endtask : settle
   task automatic wr(input logic [35:0] d);
      dcf_port_master_inst_a.xfer(1'h0, 1'h1, 1'h1, 1'h0, d);
      q.push_back(d);
   endtask : wr
   task automatic rd(input logic [35:0] exp);
      dcf_port_master_inst_b.xfer(1'h0, 1'h0, 1'h1, 1'h0, 36'h0);
      settle();
      check(pb.data, exp);
   endtask : rd
   task automatic dev_reset(input logic [1:0] fs);
      @(negedge clk);
      {fs_hi, fs_lo} = fs;
      dev_rst_n = 1'h0;
      repeat (5) @(posedge pb.clk);
      @(negedge clk);
      check(36'({full_n, empty_n, ae_n, af_n, mab_n, mba_n}), 36'h7);
      @(posedge pa.clk);
      repeat ($urandom % 3) @(negedge clk);
      dev_rst_n = 1'h1;
      @(posedge pa.clk);
      repeat (5) @(negedge clk);
      check(36'(full_n), 36'h0);
      @(posedge pa.clk);
      repeat (5) @(negedge clk);
      check(36'(full_n), 36'h1);
   endtask : dev_reset
   initial begin
      reset = 1'h1;
      dev_rst_n = 1'h1;
      fs_lo = 1'h0;
      fs_hi = 1'h0;
      void'($urandom(27779));
      repeat (3) @(negedge clk);
      reset = 1'h0;
      for (int c = 0; c < 4; c++) begin
         dev_reset(c[1:0]);
         x = ofs(c[1:0]);
         q.delete();
         for (int i = 0; i < x; i++) begin
            wr(rnd36());
            if (i == 0) begin
               dcf_port_master_inst_a.idle();
               @(posedge pb.clk);
               @(negedge clk);
               check(36'(empty_n), 36'h0);
               repeat (2) @(posedge pb.clk);
               repeat (5) @(negedge clk);
               check(36'(empty_n), 36'h1);
            end
         end
         settle();
         check(36'(ae_n), 36'h0);
         wr(rnd36());
         settle();
         check(36'(ae_n), 36'h1);
      end
      while (q.size() < 47) wr(rnd36());
      settle();
      check(36'(af_n), 36'h1);
      wr(rnd36());
      settle();
      check(36'(af_n), 36'h0);
      while (q.size() < 64) wr(rnd36());
      settle();
      check(36'(full_n), 36'h0);
      // refused write: the word must never come out
      dcf_port_master_inst_a.xfer(1'h0, 1'h1, 1'h1, 1'h0, rnd36());
      settle();
      rd(q.pop_front());
      check(36'(full_n), 36'h1);
      wr(rnd36());
      settle();
      check(36'(full_n), 36'h0);
      while (q.size() > 0) begin
         w = q.pop_front();
         rd(w);
      end
      check(36'(empty_n), 36'h0);
      rd(w);
      m1 = rnd36();
      m2 = rnd36();
      dcf_port_master_inst_a.xfer(1'h0, 1'h1, 1'h1, 1'h1, m1);
      settle();
      check(36'(mab_n), 36'h0);
      dcf_port_master_inst_a.xfer(1'h0, 1'h1, 1'h1, 1'h1, rnd36());
      // enable down first, or the write lands once port B frees the box
      dcf_port_master_inst_a.idle();
      dcf_port_master_inst_b.xfer(1'h0, 1'h0, 1'h1, 1'h1, 36'h0);
      settle();
      check(pb.data, m1);
      check(36'(mab_n), 36'h1);
      dcf_port_master_inst_b.xfer(1'h0, 1'h1, 1'h1, 1'h1, m2);
      settle();
      check(36'(mba_n), 36'h0);
      dcf_port_master_inst_a.xfer(1'h0, 1'h0, 1'h1, 1'h1, 36'h0);
      settle();
      check(pa.data, m2);
      check(36'(mba_n), 36'h1);
      for (int k = 0; k < 4; k++) begin
         dcf_port_master_inst_a.xfer(k[1], k[0], 1'h0, 1'h0, rnd36());
         dcf_port_master_inst_b.xfer(k[1], k[0], 1'h0, 1'h0, rnd36());
         repeat (4) @(negedge clk);
         check(36'({a_oe_n, b_oe_n}), (k == 0) ? 36'h0 : 36'h3);
      end
      conclude();
   end
endmodule : dual_clock_fifo_mailbox_ports_tb_top
